// ### verilog/console_sel_regs.svh
`ifndef CONSOLE_SEL_REGS_SVH
`define CONSOLE_SEL_REGS_SVH

// register byte offsets
`define REG_CONFIG_OFS      8'h00
`define REG_MASKS_OFS       8'h04
`define REG_STATUS_OFS      8'h08
`define REG_VIS_OFS         8'h0C
`define REG_ACTION_OFS      8'h10

// reset values
`define MODE_MASK_RST       8'hFF
`define PVSP_MASK_RST       4'hF
`define OUT_MASK_RST        4'hF
`define EVENT_CNT_RST       2'h0
`define ACTION_SEL_RST      4'h0
`define GROUP_COUNT_RST     4'h1

// config register fields
`define CFG_ACTION_LSB      0
`define CFG_EVCNT_LSB       4
`define CFG_GROUPS_LSB      8
`define CFG_HEATCOOL_BIT    12
`define CFG_ONOFF_BIT       13
`define CFG_HAS_REMOTE_BIT  14
`define CFG_HAS_MOTOR_BIT   15

// masks register fields
`define MSK_MODE_LSB        0
`define MSK_PVSP_LSB        8
`define MSK_OUT_LSB         12

// long-press timing
`define HOLD_TIME_MS        1000
`define CLK_FREQ_HZ         100000000
`define HOLD_CYCLES         ((`HOLD_TIME_MS * (`CLK_FREQ_HZ / 1000)))

`endif

// ### verilog/console_sel_pkg.sv
package console_sel_pkg;

    typedef enum logic [3:0] {
        ACT_NONE, ACT_AUTO_MANUAL, ACT_RUN_READY, ACT_AUTO_TUNING, ACT_GROUP_STEP,
        ACT_LATCH_RELEASE, ACT_LOCAL_REMOTE, ACT_COMM_INPUT, ACT_NONE_ALT
    } action_t;

    typedef struct packed {
        logic auto_manual;
        logic run_ready;
        logic local_remote;
        logic auto_tuning;
        logic latch_release;
        logic comm_input_one;
    } mode_vis_t;

    typedef struct packed {
        logic process_value;
        logic setpoint_value;
        logic group_number;
    } pvsp_vis_t;

    typedef struct packed {
        logic manipulated_value;
        logic heat_cool;
        logic motor_feedback_value;
        logic auto_tuning_progress;
    } out_vis_t;

    typedef struct packed {
        logic auto_manual;
        logic run_ready;
        logic auto_tuning;
        logic group_step;
        logic latch_release;
        logic local_remote;
        logic comm_input_one;
    } action_pulse_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_COUNT,
        KEY_FIRED
    } key_state_t;

endpackage

// ### verilog/console_key_and_display_select.sv
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "console_sel_regs.svh"

module console_key_and_display_select #(
    parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    input  wire logic                          i_mode_key,
    input  wire logic                          i_operation_display,
    input  wire logic                          i_pv_alarm,
    input  wire logic                          i_auto_tuning_running,
    input  wire logic [2:0]                    i_event_uses_settings,
    input  wire logic                          i_hsel,
    input  wire logic [31:0]                   i_haddr,
    input  wire logic [1:0]                    i_htrans,
    input  wire logic                          i_hwrite,
    input  wire logic [2:0]                    i_hsize,
    input  wire logic [31:0]                   i_hwdata,
    input  wire logic                          i_hready,
    output logic [31:0]                        o_hrdata,
    output logic                               o_hreadyout,
    output logic                               o_hresp,
    output console_sel_pkg::action_pulse_t     o_action,
    output console_sel_pkg::mode_vis_t         o_mode_vis,
    output console_sel_pkg::pvsp_vis_t         o_pvsp_vis,
    output console_sel_pkg::out_vis_t          o_out_vis,
    output logic [2:0]                         o_event_vis
);

    // pin synchronisers (key, alarm and option inputs arrive asynchronously)
    logic [1:0] key_sync_q;
    logic [1:0] alarm_sync_q;
    logic [1:0] run_sync_q;
    logic [1:0] opdisp_sync_q;
    logic [2:0] evuse_meta_q;
    logic [2:0] evuse_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            key_sync_q    <= 2'h0;
            alarm_sync_q  <= 2'h0;
            run_sync_q    <= 2'h0;
            opdisp_sync_q <= 2'h0;
            evuse_meta_q  <= 3'h0;
            evuse_q       <= 3'h0;
        end else if (i_ce) begin
            key_sync_q    <= {key_sync_q[0], i_mode_key};
            alarm_sync_q  <= {alarm_sync_q[0], i_pv_alarm};
            run_sync_q    <= {run_sync_q[0], i_auto_tuning_running};
            opdisp_sync_q <= {opdisp_sync_q[0], i_operation_display};
            evuse_meta_q  <= i_event_uses_settings;
            evuse_q       <= evuse_meta_q;
        end
    end

    wire key_held   = key_sync_q[1];
    wire pv_alarm   = alarm_sync_q[1];
    wire at_running = run_sync_q[1];
    wire op_display = opdisp_sync_q[1];

    // software configuration
    logic [3:0] action_sel_q;
    logic [1:0] event_cnt_q;
    logic [3:0] group_count_q;
    logic       heat_cool_q;
    logic       onoff_q;
    logic       has_remote_q;
    logic       has_motor_q;
    logic [7:0] mode_mask_q;
    logic [3:0] pvsp_mask_q;
    logic [3:0] out_mask_q;

    // ahb-lite slave, zero wait states
    logic       wr_pend_q;
    logic [7:0] addr_q;

    wire        bus_take = i_hsel && i_hready && i_htrans[1];
    wire        wr_take  = bus_take && i_hwrite;
    wire        rd_take  = bus_take && !i_hwrite;
    wire        wr_cfg   = wr_pend_q && (addr_q == `REG_CONFIG_OFS);
    wire        wr_msk   = wr_pend_q && (addr_q == `REG_MASKS_OFS);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else if (i_ce) begin
            wr_pend_q <= wr_take;
            if (bus_take) begin
                addr_q <= i_haddr[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            action_sel_q  <= `ACTION_SEL_RST;
            event_cnt_q   <= `EVENT_CNT_RST;
            group_count_q <= `GROUP_COUNT_RST;
            heat_cool_q   <= 1'b0;
            onoff_q       <= 1'b0;
            has_remote_q  <= 1'b0;
            has_motor_q   <= 1'b0;
        end else if (i_ce && wr_cfg) begin
            action_sel_q  <= i_hwdata[`CFG_ACTION_LSB +: 4];
            event_cnt_q   <= i_hwdata[`CFG_EVCNT_LSB +: 2];
            group_count_q <= i_hwdata[`CFG_GROUPS_LSB +: 4];
            heat_cool_q   <= i_hwdata[`CFG_HEATCOOL_BIT];
            onoff_q       <= i_hwdata[`CFG_ONOFF_BIT];
            has_remote_q  <= i_hwdata[`CFG_HAS_REMOTE_BIT];
            has_motor_q   <= i_hwdata[`CFG_HAS_MOTOR_BIT];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_mask_q <= `MODE_MASK_RST;
            pvsp_mask_q <= `PVSP_MASK_RST;
            out_mask_q  <= `OUT_MASK_RST;
        end else if (i_ce && wr_msk) begin
            mode_mask_q <= i_hwdata[`MSK_MODE_LSB +: 8];
            pvsp_mask_q <= i_hwdata[`MSK_PVSP_LSB +: 4];
            out_mask_q  <= i_hwdata[`MSK_OUT_LSB +: 4];
        end
    end

    wire single_group = (group_count_q == 4'h1);

    // long-press detector
    console_sel_pkg::key_state_t key_state_q;
    logic [31:0]                 hold_cnt_q;
    logic                        fire_q;

    wire hold_done = (hold_cnt_q >= HOLD_CYCLES - 1);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            key_state_q <= console_sel_pkg::KEY_IDLE;
            hold_cnt_q  <= 32'h0;
            fire_q      <= 1'b0;
        end else if (i_ce) begin
            fire_q <= 1'b0;
            case (key_state_q)
                console_sel_pkg::KEY_IDLE: begin
                    hold_cnt_q <= 32'h0;
                    if (key_held && op_display) begin
                        key_state_q <= console_sel_pkg::KEY_COUNT;
                    end
                end
                console_sel_pkg::KEY_COUNT: begin
                    // leaving the operation display restarts the hold
                    if (!key_held || !op_display) begin
                        key_state_q <= console_sel_pkg::KEY_IDLE;
                    end else if (hold_done) begin
                        fire_q      <= 1'b1;
                        key_state_q <= console_sel_pkg::KEY_FIRED;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 32'h1;
                    end
                end
                console_sel_pkg::KEY_FIRED: begin
                    if (!key_held) begin
                        key_state_q <= console_sel_pkg::KEY_IDLE;
                    end
                end
                default: key_state_q <= console_sel_pkg::KEY_IDLE;
            endcase
        end
    end

    // action decode; values 0, 8 and above do nothing
    wire                            act_ok = fire_q && (action_sel_q <= 4'h8);
    wire console_sel_pkg::action_t  act    = console_sel_pkg::action_t'(action_sel_q);
    console_sel_pkg::action_pulse_t action_d;

    assign action_d.auto_manual    = act_ok && act == console_sel_pkg::ACT_AUTO_MANUAL && !onoff_q;
    assign action_d.run_ready      = act_ok && act == console_sel_pkg::ACT_RUN_READY;
    assign action_d.auto_tuning    = act_ok && act == console_sel_pkg::ACT_AUTO_TUNING
                                     && !onoff_q && !pv_alarm;
    assign action_d.group_step     = act_ok && act == console_sel_pkg::ACT_GROUP_STEP && !single_group;
    assign action_d.latch_release  = act_ok && act == console_sel_pkg::ACT_LATCH_RELEASE;
    assign action_d.local_remote   = act_ok && act == console_sel_pkg::ACT_LOCAL_REMOTE;
    assign action_d.comm_input_one = act_ok && act == console_sel_pkg::ACT_COMM_INPUT;

    // visibility; mask bits 6/7 and process/setpoint bit 3 drive no visibility output, only the masks register read-back
    console_sel_pkg::mode_vis_t mode_vis_d;
    console_sel_pkg::pvsp_vis_t pvsp_vis_d;
    console_sel_pkg::out_vis_t  out_vis_d;
    logic [2:0]                 event_vis_d;

    assign mode_vis_d.auto_manual    = mode_mask_q[0] && !onoff_q;
    assign mode_vis_d.run_ready      = mode_mask_q[1];
    assign mode_vis_d.local_remote   = mode_mask_q[2] && has_remote_q;
    assign mode_vis_d.auto_tuning    = mode_mask_q[3] && !onoff_q;
    assign mode_vis_d.latch_release  = mode_mask_q[4];
    assign mode_vis_d.comm_input_one = mode_mask_q[5];

    assign pvsp_vis_d.process_value  = pvsp_mask_q[0];
    assign pvsp_vis_d.setpoint_value = pvsp_mask_q[1];
    assign pvsp_vis_d.group_number   = pvsp_mask_q[2] && !single_group;

    assign out_vis_d.manipulated_value    = out_mask_q[0];
    assign out_vis_d.heat_cool            = out_mask_q[1] && heat_cool_q;
    assign out_vis_d.motor_feedback_value = out_mask_q[2] && has_motor_q;
    assign out_vis_d.auto_tuning_progress = out_mask_q[3] && at_running;

    // only three event slots exist, so events four to eight cannot appear
    assign event_vis_d[0] = (event_cnt_q >= 2'h1) && evuse_q[0];
    assign event_vis_d[1] = (event_cnt_q >= 2'h2) && evuse_q[1];
    assign event_vis_d[2] = (event_cnt_q == 2'h3) && evuse_q[2];

    // read mux
    wire [31:0] cfg_word = {16'h0, has_motor_q, has_remote_q, onoff_q, heat_cool_q,
                            group_count_q, 2'h0, event_cnt_q, action_sel_q};
    wire [31:0] msk_word = {16'h0, out_mask_q, pvsp_mask_q, mode_mask_q};
    wire [31:0] sts_word = {28'h0, at_running, pv_alarm, key_held,
                            key_state_q == console_sel_pkg::KEY_FIRED};
    wire [31:0] vis_word = {13'h0, event_vis_d, out_vis_d, 1'b0, pvsp_vis_d, 2'h0, mode_vis_d};
    logic [31:0] rdata_d;

    always_comb begin
        case (i_haddr[7:0])
            `REG_CONFIG_OFS: rdata_d = cfg_word;
            `REG_MASKS_OFS:  rdata_d = msk_word;
            `REG_STATUS_OFS: rdata_d = sts_word;
            `REG_VIS_OFS:    rdata_d = vis_word;
            `REG_ACTION_OFS: rdata_d = {28'h0, action_sel_q};
            default:         rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hrdata    <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            o_action    <= '0;
            o_mode_vis  <= '0;
            o_pvsp_vis  <= '0;
            o_out_vis   <= '0;
            o_event_vis <= 3'h0;
        end else if (i_ce) begin
            if (rd_take) begin
                o_hrdata <= rdata_d;
            end
            o_action    <= action_d;
            o_mode_vis  <= mode_vis_d;
            o_pvsp_vis  <= pvsp_vis_d;
            o_out_vis   <= out_vis_d;
            o_event_vis <= event_vis_d;
        end
    end

endmodule

// ### testbench/console_checker_properties.sv
`timescale 1ns/100ps
module console_checker #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    input wire logic                            i_clk,
    input wire logic                            i_rst,
    input wire logic                            i_mode_key,
    input wire logic                            i_operation_display,
    input wire logic                            i_pv_alarm,
    input wire logic                            i_auto_tuning_running,
    input wire logic [2:0]                      i_event_uses_settings,
    input wire logic                            o_hreadyout,
    input wire logic                            o_hresp,
    input wire console_sel_pkg::action_pulse_t  o_action,
    input wire console_sel_pkg::out_vis_t       o_out_vis,
    input wire logic [2:0]                      o_event_vis
);
    int unsigned held_q;
    logic        fired_q;
    // raw pin is watched: the synchroniser only delays, so the raw hold time is an upper bound
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            held_q <= 0;
            fired_q <= 1'b0;
        end else begin
            held_q <= i_mode_key ? held_q + 1 : 0;
            fired_q <= i_mode_key && (fired_q || o_action != 7'h00);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_fire;
        o_action != 7'h00;
    endsequence
    a_bus_always_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1) else $error("bus answer wrong");
    a_pulse_one_cycle: assert property (s_fire |=> o_action == 7'h00) else $error("action longer than one cycle");
    a_single_action: assert property ($onehot0(o_action)) else $error("several actions at once");
    a_hold_long_enough: assert property (s_fire |-> held_q >= HOLD_CYCLES) else $error("action before full hold");
    a_rearm_on_release: assert property (s_fire |-> !fired_q) else $error("second action in one hold");
    // the fire decision sees the display pin two sync stages late, then fire and output registers follow
    a_display_mode_only: assert property (s_fire |-> $past(i_operation_display, 4)) else $error("action outside display");
    a_alarm_blocks_tuning: assert property (o_action.auto_tuning |-> !$past(i_pv_alarm, 3)) else $error("tuning under alarm");
    a_progress_needs_tuning: assert property ($rose(o_out_vis.auto_tuning_progress) |-> $past(i_auto_tuning_running, 3))
        else $error("progress while tuning stopped");
    a_event_type_gate: assert property ((o_event_vis & ~$past(i_event_uses_settings, 3)) == 3'h0)
        else $error("event shown without settings");
endmodule
bind console_key_and_display_select console_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_console_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_mode_key(i_mode_key), .i_operation_display(i_operation_display),
    .i_pv_alarm(i_pv_alarm), .i_auto_tuning_running(i_auto_tuning_running),
    .i_event_uses_settings(i_event_uses_settings), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_action(o_action), .o_out_vis(o_out_vis), .o_event_vis(o_event_vis));

// ### testbench/panel_model.sv
`timescale 1ns/100ps
// front panel: presses the mode key on request and collects the action pulses of one press
module panel_model (
    input  wire logic       i_clk,
    input  wire logic       i_press,
    input  wire logic [6:0] i_action,
    output logic            o_mode_key,
    output logic [6:0]      o_seen,
    output int              o_pulses
);
    logic press_q = 1'b0;
    initial begin
        o_mode_key = 1'b0;
        o_seen = 7'h00;
        o_pulses = 0;
    end
    always @(posedge i_clk) begin
        press_q <= i_press;
        o_mode_key <= i_press;
        if (i_press && !press_q) begin
            o_seen <= 7'h00;
            o_pulses <= 0;
        end else if (i_action != 7'h00) begin
            o_seen <= o_seen | i_action;
            o_pulses <= o_pulses + 1;
        end
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned HOLD = 20;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        press = 1'b0;
    logic        disp = 1'b1;
    logic        alarm = 1'b0;
    logic        atr = 1'b0;
    logic [2:0]  uses = 3'h0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        key;
    logic [6:0]  seen;
    int          pulses;
    logic [15:0] seed = 16'h4FF0;
    logic [15:0] cfg;
    logic [15:0] msk;
    logic [31:0] rd;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    console_sel_pkg::action_pulse_t action;
    console_sel_pkg::mode_vis_t     mode_vis;
    console_sel_pkg::pvsp_vis_t     pvsp_vis;
    console_sel_pkg::out_vis_t      out_vis;
    logic [2:0]                     event_vis;
    wire logic [15:0]               vis = {mode_vis, pvsp_vis, out_vis, event_vis};
    console_key_and_display_select #(.HOLD_CYCLES(HOLD)) u_console_key_and_display_select (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_mode_key(key), .i_operation_display(disp),
        .i_pv_alarm(alarm), .i_auto_tuning_running(atr), .i_event_uses_settings(uses), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_action(action),
        .o_mode_vis(mode_vis), .o_pvsp_vis(pvsp_vis), .o_out_vis(out_vis), .o_event_vis(event_vis));
    panel_model u_panel_model (.i_clk(i_clk), .i_press(press), .i_action(action), .o_mode_key(key),
        .o_seen(seen), .o_pulses(pulses));
    initial forever #5 i_clk = ~i_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_vis(input logic [15:0] c, input logic [15:0] m, input logic t,
                                            input logic [2:0] u);
        logic [2:0] ev;
        ev = {c[5:4] > 2'h2, c[5:4] > 2'h1, c[5:4] > 2'h0} & u;
        return {m[0] & ~c[13], m[1], m[2] & c[14], m[3] & ~c[13], m[4], m[5], m[8], m[9],
                m[10] & (c[11:8] != 4'h1), m[12], m[13] & c[12], m[14] & c[15], m[15] & t, ev};
    endfunction
    function automatic logic [6:0] exp_act(input logic [3:0] s, input logic onoff, input logic al,
                                           input logic [3:0] g);
        logic [6:0] a;
        // selector 0 and 8 and above shift the one-hot bit out of range, leaving no action
        a = 7'(8'h80 >> s);
        return a & ~{onoff, 1'b0, onoff | al, g == 4'h1, 3'h0};
    endfunction
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        rd = hrdata;
    endtask
    task automatic press_for(input int n);
        press <= 1'b1;
        repeat (n) @(posedge i_clk);
        press <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: word %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chk_key(input logic [6:0] got, input int n, input logic [6:0] exp);
        checks_done++;
        if (got !== exp || n != int'(exp != 7'h00)) begin
            bad_count++;
            $display("unexpected at %0t: actions %h x%0d, want %h", $time, got, n, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd, 32'h0100);
        ahb(1'b0, 32'h4, 32'h0);
        chk_word(rd, 32'hFFFF);
        ahb(1'b0, 32'h14, 32'h0);
        chk_word(rd, 32'h0);
        chk_word({16'h0, vis}, {16'h0, exp_vis(16'h0100, 16'hFFFF, 1'b0, 3'h0)});
        $display("register test done");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            cfg = (i == 0) ? 16'hD230 : {seed[15:12], 2'h0, seed[9:4], 4'h0};
            atr <= (i == 0) | seed[0];
            uses <= (i == 0) ? 3'h7 : seed[3:1];
            seed = lfsr(seed);
            msk = (i == 0) ? 16'hFFFF : seed;
            ahb(1'b1, 32'h0, {16'h0, cfg});
            ahb(1'b1, 32'h4, {16'h0, msk});
            repeat (6) @(posedge i_clk);
            chk_word({16'h0, vis}, {16'h0, exp_vis(cfg, msk, atr, uses)});
        end
        $display("display test done");
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            cfg = {2'h0, seed[0], 1'b0, 2'h0, seed[2:1], 4'h0, 4'(i % 10)};
            alarm <= seed[3];
            ahb(1'b1, 32'h0, {16'h0, cfg});
            repeat (4) @(posedge i_clk);
            press_for(2 * HOLD + 8);
            chk_key(seen, pulses, exp_act(cfg[3:0], seed[0], seed[3], cfg[11:8]));
        end
        ahb(1'b1, 32'h0, 32'h0102);
        press_for(HOLD / 2);
        chk_key(seen, pulses, 7'h00);
        disp <= 1'b0;
        press_for(2 * HOLD + 8);
        chk_key(seen, pulses, 7'h00);
        disp <= 1'b1;
        press_for(HOLD + 8);
        chk_key(seen, pulses, 7'h20);
        ahb(1'b0, 32'h10, 32'h0);
        chk_word(rd, 32'h2);
        $display("key test done");
        // a mid-run reset must bring every setting back to its default
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd, 32'h0100);
        ahb(1'b0, 32'h4, 32'h0);
        chk_word(rd, 32'hFFFF);
        $display("reset test done");
        end_of_test();
    end
endmodule
